//--- rtl/homing_params.svh
// Constants of the servo homing sequencer: offsets, field positions, resets, limits.
// Assumes inclusion by the modules of this block only.
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

// Register indices on the parameter port
`define REG_MODE_SELECT   2'h0
`define REG_FAST_SPEED    2'h1
`define REG_SLOW_SPEED    2'h2
`define REG_NEXT_PATH     2'h3

// Mode word fields: method, signal setting, limit setting
`define MODE_METHOD_LSB   0
`define MODE_SIGNAL_LSB   4
`define MODE_LIMIT_LSB    8

// Speeds in tenths of rpm
`define FAST_SPEED_MIN    16'h0001
`define FAST_SPEED_MAX    16'h4e20
`define FAST_SPEED_RESET  16'h03e8
`define SLOW_SPEED_MIN    16'h0001
`define SLOW_SPEED_MAX    16'h1388
`define SLOW_SPEED_RESET  16'h00c8
`define MODE_RESET        16'h0000
`define NEXT_PATH_RESET   8'h00

`define RESP_OK           8'h00
`define RESP_VALUE_ERROR  8'h03

// Standstill qualification: 1 us at 250 MHz
`define STILL_TIME_NS     1000
`define CLK_PERIOD_NS     4
`define STILL_CYCLES      (`STILL_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/homing_pkg.sv
// Types shared by the homing sequencer modules.
// Assumes homing_params.svh sits on the include path.
package homing_pkg;
	typedef enum logic [3:0] {
		M_POS_LIMIT_FWD  = 4'h0,
		M_NEG_LIMIT_REV  = 4'h1,
		M_ORG_RISE_FWD   = 4'h2,
		M_ORG_RISE_REV   = 4'h3,
		M_INDEX_FWD      = 4'h4,
		M_INDEX_REV      = 4'h5,
		M_ORG_FALL_FWD   = 4'h6,
		M_ORG_FALL_REV   = 4'h7,
		M_CURRENT_POS    = 4'h8
	} method_t;

	typedef enum logic [1:0] {
		SIG_RETURN_INDEX = 2'h0,
		SIG_FORWARD_INDEX = 2'h1,
		SIG_NO_INDEX     = 2'h2
	} signal_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_FAST    = 3'b001,
		ST_SLOW    = 3'b010,
		ST_INDEX   = 3'b011,
		ST_SETTLE  = 3'b100,
		ST_DONE    = 3'b101,
		ST_ERROR   = 3'b110
	} home_state_t;
endpackage

//--- rtl/homing_cfg_if.sv
// Configuration carried from the parameter store to the sequencer core.
// Assumes one clock domain; all fields are registered in the store.
`timescale 1ns/1ps
interface homing_cfg_if;
	logic [15:0] mode_word;
	logic [15:0] fast_speed;
	logic [15:0] slow_speed;
	logic [7:0]  next_path;

	modport store (output mode_word, output fast_speed, output slow_speed, output next_path);
	modport core  (input mode_word, input fast_speed, input slow_speed, input next_path);
endinterface

//--- rtl/homing_param_store.sv
// Parameter store: mode word, both homing speeds, next-path selection.
// Assumes a one-cycle write strobe; reads are combinational on the index.
`timescale 1ns/1ps
`include "homing_params.svh"
module homing_param_store import homing_pkg::*; (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       wr_en,
	input  wire logic [1:0] wr_index,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0] rd_index,
	output logic [15:0]     rd_data,
	output logic [7:0]      wr_resp,
	output logic            wr_resp_valid,
	homing_cfg_if.store     cfg
);
	logic [15:0] mode_q, fast_q, slow_q;
	logic [7:0]  path_q, resp_q;
	logic        resp_v_q;

	wire fast_sel = wr_en && wr_index == `REG_FAST_SPEED;
	wire slow_sel = wr_en && wr_index == `REG_SLOW_SPEED;
	wire fast_ok  = wr_data >= `FAST_SPEED_MIN && wr_data <= `FAST_SPEED_MAX;
	wire slow_ok  = wr_data >= `SLOW_SPEED_MIN && wr_data <= `SLOW_SPEED_MAX;
	wire reject   = (fast_sel && !fast_ok) || (slow_sel && !slow_ok);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_q   <= `MODE_RESET;
			fast_q   <= `FAST_SPEED_RESET;
			slow_q   <= `SLOW_SPEED_RESET;
			path_q   <= `NEXT_PATH_RESET;
			resp_q   <= `RESP_OK;
			resp_v_q <= 1'b0;
		end else begin
			resp_v_q <= wr_en;
			if (wr_en)
				resp_q <= reject ? `RESP_VALUE_ERROR : `RESP_OK;
			if (wr_en && wr_index == `REG_MODE_SELECT)
				mode_q <= wr_data;
			if (fast_sel && fast_ok)
				fast_q <= wr_data;
			if (slow_sel && slow_ok)
				slow_q <= wr_data;
			if (wr_en && wr_index == `REG_NEXT_PATH)
				path_q <= wr_data[7:0];
		end
	end

	assign rd_data = rd_index == `REG_MODE_SELECT ? mode_q :
	                 rd_index == `REG_FAST_SPEED  ? fast_q :
	                 rd_index == `REG_SLOW_SPEED  ? slow_q : {8'h00, path_q};
	assign wr_resp       = resp_q;
	assign wr_resp_valid = resp_v_q;
	assign cfg.mode_word  = mode_q;
	assign cfg.fast_speed = fast_q;
	assign cfg.slow_speed = slow_q;
	assign cfg.next_path  = path_q;
endmodule

//--- rtl/homing_still_detect.sv
// Standstill detector: motion flag must stay low for a whole qualify window.
// Assumes motor_moving is already synchronous to ref_clk.
`timescale 1ns/1ps
`include "homing_params.svh"
module homing_still_detect #(
	parameter int STILL_CYCLES = `STILL_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic clear,
	input  wire logic motor_moving,
	output logic      still
);
	localparam int CW = $clog2(STILL_CYCLES + 1);
	logic [CW-1:0] cnt_q;
	wire at_end = cnt_q == CW'(STILL_CYCLES);

	always_ff @(posedge ref_clk) begin
		if (reset || clear || motor_moving)
			cnt_q <= '0;
		else if (!at_end)
			cnt_q <= cnt_q + CW'(1);
	end

	assign still = at_end;
endmodule

//--- rtl/servo_homing_sequencer.sv
// Homing sequencer top: searches the chosen reference, slows, finds index, sets origin.
// Assumes limits, origin sensor, index pulse and motion flag are synchronous to ref_clk.
`timescale 1ns/1ps
`include "homing_params.svh"
module servo_homing_sequencer import homing_pkg::*; #(
	parameter int STILL_CYCLES = `STILL_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        param_wr_en,
	input  wire logic [1:0]  param_wr_index,
	input  wire logic [15:0] param_wr_data,
	input  wire logic [1:0]  param_rd_index,
	output logic [15:0]      param_rd_data,
	output logic [7:0]       param_wr_resp,
	output logic             param_wr_resp_valid,
	input  wire logic        homing_start,
	input  wire logic        boot_homing_enable,
	input  wire logic        servo_on,
	input  wire logic        positive_limit_switch,
	input  wire logic        negative_limit_switch,
	input  wire logic        origin_sensor_input,
	input  wire logic        index_pulse,
	input  wire logic        motor_moving,
	output logic             motor_run,
	output logic             motor_reverse,
	output logic [15:0]      motor_speed,
	output logic             motor_stop,
	output logic             homing_busy,
	output logic             homing_done,
	output logic             homing_error,
	output logic             origin_capture,
	output logic             coord_valid,
	output logic             soft_limit_enable,
	output logic             next_path_start,
	output logic [7:0]       motion_path
);
	homing_cfg_if cfg ();

	homing_param_store u_store (
		.ref_clk       (ref_clk),
		.reset         (reset),
		.wr_en         (param_wr_en),
		.wr_index      (param_wr_index),
		.wr_data       (param_wr_data),
		.rd_index      (param_rd_index),
		.rd_data       (param_rd_data),
		.wr_resp       (param_wr_resp),
		.wr_resp_valid (param_wr_resp_valid),
		.cfg           (cfg.store)
	);

	home_state_t state_q, state_d;
	logic        still;
	logic        rev_q, rev_d;
	logic        org_q, boot_done_q, servo_on_q;
	logic        done_q, err_q, coord_q, cap_q, next_q;
	logic [7:0]  path_q;
	logic [15:0] speed_q;

	homing_still_detect #(.STILL_CYCLES(STILL_CYCLES)) u_still (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.clear        (state_q != ST_SETTLE),
		.motor_moving (motor_moving),
		.still        (still)
	);

	// Decoded mode fields
	wire [3:0] method  = cfg.mode_word[`MODE_METHOD_LSB +: 4];
	wire [3:0] sig_fld = cfg.mode_word[`MODE_SIGNAL_LSB +: 4];
	wire [3:0] lim_fld = cfg.mode_word[`MODE_LIMIT_LSB +: 4];
	wire       lim_rev = lim_fld[0];
	// Unknown method codes fall back to the current-position case (no motion)
	wire       cur_pos = method >= 4'h8;
	wire       start_rev = method[0];
	wire       org_rise = origin_sensor_input && !org_q;
	wire       org_fall = !origin_sensor_input && org_q;

	// Reference hit for the selected method
	wire ref_hit = (method == M_POS_LIMIT_FWD) ? positive_limit_switch :
	               (method == M_NEG_LIMIT_REV) ? negative_limit_switch :
	               (method == M_ORG_RISE_FWD || method == M_ORG_RISE_REV) ? org_rise :
	               (method == M_INDEX_FWD || method == M_INDEX_REV) ? index_pulse :
	               (method == M_ORG_FALL_FWD || method == M_ORG_FALL_REV) ? org_fall :
	               1'b0;
	wire index_mode = method == M_INDEX_FWD || method == M_INDEX_REV;
	wire limit_mode = method == M_POS_LIMIT_FWD || method == M_NEG_LIMIT_REV;
	// A limit hit in the travel direction; never counted in the two limit methods, whichever limit it is
	wire lim_hit = !limit_mode &&
	               ((!rev_q && positive_limit_switch) || (rev_q && negative_limit_switch));
	// Index methods or the no-index setting: the reference hit is the origin, no follow-up search
	wire skip_index = index_mode || sig_fld == 4'(SIG_NO_INDEX);

	// Power-up homing on the first servo-on after reset
	wire boot_go  = boot_homing_enable && !boot_done_q && servo_on && !servo_on_q;
	wire start_go = homing_start || boot_go;

	always_comb begin
		state_d = state_q;
		rev_d   = rev_q;
		unique case (state_q)
			ST_IDLE, ST_DONE, ST_ERROR: begin
				if (start_go) begin
					rev_d   = start_rev;
					state_d = cur_pos ? ST_SETTLE : ST_FAST;
				end
			end
			ST_FAST: begin
				if (ref_hit) begin
					state_d = ST_SLOW;
					if (!skip_index && sig_fld == 4'(SIG_RETURN_INDEX))
						rev_d = !rev_q;
				end else if (lim_hit) begin
					if (lim_rev)
						rev_d = !rev_q;
					else
						state_d = ST_ERROR;
				end
			end
			ST_SLOW: begin
				state_d = skip_index ? ST_SETTLE : ST_INDEX;
			end
			ST_INDEX: begin
				if (index_pulse)
					state_d = ST_SETTLE;
				else if (lim_hit)
					state_d = ST_ERROR;
			end
			ST_SETTLE: begin
				if (still)
					state_d = ST_DONE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	wire entering_done = state_q != ST_DONE && state_d == ST_DONE;
	wire moving_state  = state_q == ST_FAST || state_q == ST_SLOW || state_q == ST_INDEX;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q     <= ST_IDLE;
			rev_q       <= 1'b0;
			org_q       <= 1'b0;
			servo_on_q  <= 1'b0;
			boot_done_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			rev_q      <= rev_d;
			org_q      <= origin_sensor_input;
			servo_on_q <= servo_on;
			if (boot_go)
				boot_done_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			coord_q <= 1'b0;
			cap_q   <= 1'b0;
			next_q  <= 1'b0;
			path_q  <= 8'h00;
			speed_q <= 16'h0000;
		end else begin
			// Completion wins over a start arriving the same cycle
			if (entering_done)
				done_q <= 1'b1;
			else if (start_go)
				done_q <= 1'b0;
			if (state_d == ST_ERROR && state_q != ST_ERROR)
				err_q <= 1'b1;
			else if (start_go)
				err_q <= 1'b0;
			if (entering_done)
				coord_q <= 1'b1;
			else if (start_go)
				coord_q <= 1'b0;
			cap_q   <= entering_done;
			// Zero selection means stop: no follow-on path is launched
			next_q  <= entering_done && cfg.next_path != 8'h00;
			path_q  <= cfg.next_path;
			speed_q <= (state_d == ST_FAST) ? cfg.fast_speed :
			           (state_d == ST_SLOW || state_d == ST_INDEX) ? cfg.slow_speed :
			           16'h0000;
		end
	end

	assign motor_run         = moving_state;
	assign motor_reverse     = rev_q;
	assign motor_speed       = speed_q;
	// Settle only decelerates where it stands; no move back to the exact origin
	assign motor_stop        = state_q == ST_SETTLE;
	assign homing_busy       = state_q != ST_IDLE && state_q != ST_DONE && state_q != ST_ERROR;
	assign homing_done       = done_q;
	assign homing_error      = err_q;
	assign origin_capture    = cap_q;
	assign coord_valid       = coord_q;
	assign soft_limit_enable = !homing_busy;
	assign next_path_start   = next_q;
	assign motion_path       = path_q;
endmodule

//--- sim/servo_homing_sequencer_chk.sv
// Timing checker of the homing sequencer top.
// Assumes the single ref_clk domain; bound to every instance of the top.
`timescale 1ns/1ps
module servo_homing_sequencer_chk #(
	parameter int STILL_CYCLES = 250
) (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        param_wr_en,
	input wire logic [1:0]  param_wr_index,
	input wire logic [15:0] param_wr_data,
	input wire logic [7:0]  param_wr_resp,
	input wire logic        param_wr_resp_valid,
	input wire logic        homing_start,
	input wire logic        motor_moving,
	input wire logic        motor_run,
	input wire logic        motor_stop,
	input wire logic        homing_busy,
	input wire logic        homing_done,
	input wire logic        homing_error,
	input wire logic        origin_capture,
	input wire logic        coord_valid,
	input wire logic        soft_limit_enable,
	input wire logic        next_path_start,
	input wire logic [7:0]  motion_path
);
	logic [15:0] quiet_q;
	wire         low_d = param_wr_data == 16'h0000;
	wire         bad_d = (param_wr_index == 2'h1 && (low_d || param_wr_data > 16'h4e20))
	             || (param_wr_index == 2'h2 && (low_d || param_wr_data > 16'h1388));

	// Saturates so a long pause never wraps back to zero
	always_ff @(posedge ref_clk) begin
		if (reset || motor_moving)
			quiet_q <= 16'h0000;
		else if (quiet_q != 16'hffff)
			quiet_q <= quiet_q + 16'h0001;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_taken;
		homing_busy && !homing_done;
	endsequence
	// Capture is a one-cycle pulse landing with the done flag
	sequence s_capture;
		origin_capture && coord_valid ##1 !origin_capture;
	endsequence

	AST_WR_RESP: assert property (param_wr_en |=> param_wr_resp_valid)
		else $error("write not answered");
	AST_RANGE: assert property (param_wr_en && bad_d |=> param_wr_resp == 8'h03)
		else $error("out of range speed accepted");
	AST_SOFT_LIMIT: assert property (soft_limit_enable != homing_busy)
		else $error("soft limit active while homing");
	AST_START: assert property (homing_start && !homing_busy |=> s_taken)
		else $error("start not taken");
	AST_DONE_CAPTURE: assert property ($rose(homing_done) |-> s_capture)
		else $error("origin not captured");
	AST_BUSY_SOFT: assert property (motor_run || motor_stop |-> homing_busy && !soft_limit_enable)
		else $error("soft limit active while motor homing");
	AST_NEXT_PATH_RUN: assert property (next_path_start == (origin_capture && motion_path != 8'h00))
		else $error("next path launch mismatch");
	AST_NEXT_PATH_ZERO: assert property (origin_capture && motion_path == 8'h00 |-> !next_path_start)
		else $error("path run after stop selection");
	AST_HALT: assert property (motor_stop || homing_done || homing_error |-> !motor_run)
		else $error("motor driven after stop");
	AST_SETTLE_QUIET: assert property ($fell(motor_stop) |-> homing_done && quiet_q >= STILL_CYCLES)
		else $error("done without standstill");
endmodule

bind servo_homing_sequencer servo_homing_sequencer_chk #(.STILL_CYCLES(STILL_CYCLES)) u_chk (
	.ref_clk(ref_clk), .reset(reset), .param_wr_en(param_wr_en), .param_wr_index(param_wr_index),
	.param_wr_data(param_wr_data), .param_wr_resp(param_wr_resp), .param_wr_resp_valid(param_wr_resp_valid),
	.homing_start(homing_start), .motor_moving(motor_moving), .motor_run(motor_run), .motor_stop(motor_stop),
	.homing_busy(homing_busy), .homing_done(homing_done), .homing_error(homing_error),
	.origin_capture(origin_capture), .coord_valid(coord_valid), .soft_limit_enable(soft_limit_enable),
	.next_path_start(next_path_start), .motion_path(motion_path));

//--- sim/homing_motor_model.sv
// Motor and encoder stand-in: motion flag with a coast tail, one index per turn.
// Assumes motor_run comes straight from the sequencer on ref_clk.
`timescale 1ns/1ps
module homing_motor_model #(
	parameter int COAST = 3,
	parameter int TURN  = 12
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic motor_run,
	output logic      motor_moving,
	output logic      index_pulse
);
	int coast_q;
	int angle_q;

	// Angle restarts at standstill so the first index never lands in the fast check
	always @(posedge ref_clk) begin
		if (reset)
			coast_q <= 0;
		else if (motor_run)
			coast_q <= COAST;
		else if (coast_q > 0)
			coast_q <= coast_q - 1;
		angle_q <= motor_moving ? (angle_q + 1) % TURN : 0;
	end
	assign motor_moving = motor_run || coast_q > 0;
	assign index_pulse  = motor_moving && angle_q == TURN - 1;
endmodule

//--- sim/servo_homing_sequencer_test.sv
// Bench of the homing sequencer: registers, every search method, limits, boot start.
// Assumes the motor model gives motion and index; switches change on falling edges.
`timescale 1ns/1ps
module servo_homing_sequencer_test import homing_pkg::*;;
	logic        ref_clk = 0, reset = 1, param_wr_en = 0, homing_start = 0, boot_homing_enable = 0, servo_on = 0;
	logic        positive_limit_switch = 0, negative_limit_switch = 0, origin_sensor_input = 0;
	logic [1:0]  param_wr_index = 0, param_rd_index = 0;
	logic [15:0] param_wr_data = 0, param_rd_data, motor_speed;
	logic [7:0]  param_wr_resp, motion_path;
	logic        param_wr_resp_valid, index_pulse, motor_moving, motor_run, motor_reverse, motor_stop;
	logic        homing_busy, homing_done, homing_error, origin_capture, coord_valid, soft_limit_enable;
	logic        next_path_start;
	logic [15:0] regs [4];
	logic [15:0] corner [6] = '{16'h0000, 16'h4e21, 16'h4e20, 16'h0000, 16'h1389, 16'h1388};
	logic [31:0] seed = 32'h1d8c;
	int          n_errors = 0;
	int          cmp_count = 0;

	always #2 ref_clk = ~ref_clk;

	servo_homing_sequencer #(.STILL_CYCLES(4)) u_dut (.ref_clk, .reset, .param_wr_en, .param_wr_index,
		.param_wr_data, .param_rd_index, .param_rd_data, .param_wr_resp, .param_wr_resp_valid, .homing_start,
		.boot_homing_enable, .servo_on, .positive_limit_switch, .negative_limit_switch, .origin_sensor_input,
		.index_pulse, .motor_moving, .motor_run, .motor_reverse, .motor_speed, .motor_stop, .homing_busy,
		.homing_done, .homing_error, .origin_capture, .coord_valid, .soft_limit_enable, .next_path_start,
		.motion_path);
	homing_motor_model u_motor (.ref_clk, .reset, .motor_run, .motor_moving, .index_pulse);

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] exp_resp(input logic [1:0] i, input logic [15:0] d);
		return ((i == 2'h1 && (d == 0 || d > 16'h4e20)) || (i == 2'h2 && (d == 0 || d > 16'h1388))) ? 8'h03 : 8'h00;
	endfunction
	// Return-to-index flips the travel; index-only methods never flip
	function automatic logic exp_dir(input logic [15:0] m);
		return m[0] ^ (m[7:4] == 4'h0 && !(m[3:0] inside {4'h4, 4'h5}));
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wait_for(input int sel, input int limit);
		for (int k = 0; k < limit; k++) begin
			if ((sel == 0 && motor_run) || (sel == 1 && motor_speed === regs[2]) || (sel == 2 && homing_done)
				|| (sel == 3 && homing_error) || (sel == 4 && homing_busy))
				return;
			@(negedge ref_clk);
		end
	endtask
	task automatic wr(input logic [1:0] i, input logic [15:0] d);
		param_wr_en = 1;
		param_wr_index = i;
		param_wr_data = d;
		@(negedge ref_clk);
		param_wr_en = 0;
		param_rd_index = i;
		chk("resp_valid", 1, param_wr_resp_valid);
		chk("resp", exp_resp(i, d), param_wr_resp);
		if (exp_resp(i, d) == 8'h00)
			regs[i] = i == 2'h3 ? {8'h00, d[7:0]} : d;
		#1 chk("readback", regs[i], param_rd_data);
		// Next request starts on a falling edge again
		@(negedge ref_clk);
	endtask
	task automatic go(input logic [15:0] m);
		wr(2'h0, m);
		origin_sensor_input = m[3:0] inside {4'h6, 4'h7};
		homing_start = 1;
		step(1);
		homing_start = 0;
	endtask
	task automatic home(input logic [15:0] m);
		go(m);
		if (m[3:0] >= 4'h8) begin
			chk("run_m8", 0, motor_run);
			chk("stop_m8", 1, motor_stop);
		end else begin
			wait_for(0, 5);
			chk("fast", regs[1], motor_speed);
			chk("soft_lim", 0, soft_limit_enable);
			chk("dir", m[0], motor_reverse);
			chk("done_clr", 0, homing_done);
			step(3);
			positive_limit_switch = m[3:0] == 4'h0;
			negative_limit_switch = m[3:0] == 4'h1;
			origin_sensor_input = !origin_sensor_input;
			wait_for(1, 40);
			chk("slow", regs[2], motor_speed);
			chk("ref_dir", exp_dir(m), motor_reverse);
			positive_limit_switch = 0;
			negative_limit_switch = 0;
		end
		wait_for(2, 200);
		chk("done", 1, homing_done);
		chk("halt", 0, motor_run);
		// Capture and next-path pulses stand only in the cycle done rises
		chk("capture", 1, origin_capture);
		chk("next", regs[3] != 0, next_path_start);
		chk("soft_lim_on", 1, soft_limit_enable);
		step(1);
		chk("capture_end", 0, origin_capture);
		chk("coord", 1, coord_valid);
		origin_sensor_input = 0;
		$display("homing %h finished", m);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#20000;
		n_errors++;
		end_of_test;
	end

	initial begin
		regs = '{16'h0000, 16'h03e8, 16'h00c8, 16'h0000};
		step(2);
		reset = 0;
		for (int j = 0; j < 4; j++) begin
			param_rd_index = j[1:0];
			#1 chk("reset_val", regs[j], param_rd_data);
			step(1);
		end
		foreach (corner[j])
			wr(j < 3 ? 2'h1 : 2'h2, corner[j]);
		for (int j = 0; j < 12; j++) begin
			seed = xorshift(seed);
			wr(seed[16] ? 2'h2 : 2'h1, seed[20] ? seed[15:0] : {3'h0, seed[12:0]});
		end
		wr(2'h1, 16'h0400);
		wr(2'h2, 16'h0040);
		$display("register test finished");
		for (int j = 0; j < 8; j++)
			home({8'h00, 4'h2, j[3:0]});
		home(16'h0002);
		home(16'h0013);
		home(16'h0008);
		home(16'h0009);
		go(16'h0022);
		step(3);
		positive_limit_switch = 1;
		wait_for(3, 10);
		chk("lim_err", 1, homing_error);
		positive_limit_switch = 0;
		go(16'h0122);
		step(3);
		positive_limit_switch = 1;
		step(3);
		chk("lim_rev", 1, motor_reverse);
		positive_limit_switch = 0;
		origin_sensor_input = 1;
		wait_for(2, 200);
		chk("lim_done", 1, homing_done);
		origin_sensor_input = 0;
		$display("limit test finished");
		wr(2'h3, 16'h0005);
		home(16'h0008);
		chk("path", 16'h0005, {8'h00, motion_path});
		boot_homing_enable = 1;
		reset = 1;
		step(2);
		reset = 0;
		step(2);
		chk("boot_idle", 0, homing_busy);
		servo_on = 1;
		wait_for(4, 4);
		chk("boot", 1, homing_busy);
		reset = 1;
		step(2);
		reset = 0;
		chk("rst_busy", 0, homing_busy);
		$display("boot test finished");
		end_of_test;
	end
endmodule
